/* rtl/pcb_device.sv */
// device end: command registers, write guards, limit monitors
// assumes host issues single-cycle requests and waits for rsp_valid
//
// Functional notes
// - phase and frequency writes only while off
// - running write: discard, raise busy fault
// - frequency change flags loss of lock
// - zero selects external oscillator, fixed codes
// - frequency and input limits are linear words
// - host keeps shared amplifier bit clear
// - input overvoltage fault above limit
// - input undervoltage warning below level
// - start conversion at start threshold
// - stop conversion at stop threshold
// - format byte reads fixed 0x14
// - host keeps margin high above nominal
// - host keeps margin low below nominal
// - cap commanded output at ceiling
// - read-only hard maximum output word
// - output overvoltage fault above limit
// - output undervoltage fault below limit
// - output warnings set status bits and alert unless masked; input warning sets status only
`timescale 1ns/1ns
module pcb_device #(
  parameter int ADC_CYCLES = pcb_pkg::ADC_LAG_CYCLES
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  pcb_if.dev bus,
  input wire logic [1:0] run,
  input wire logic [1:0] op_on,
  input wire logic [1:0][1:0] margin_sel,
  input wire logic [15:0] vin_level,
  input wire logic [1:0][15:0] vout_sense,
  output logic [1:0] conv_enable,
  output logic [1:0][15:0] vout_target,
  output logic [7:0] phase_config,
  output logic [15:0] freq_select,
  output logic ext_osc,
  output logic pll_unlock,
  output logic busy_fault,
  output logic vin_ov_fault,
  output logic vin_uv_warn,
  output logic [1:0] vout_ov_fault,
  output logic [1:0] vout_uv_fault,
  output logic [1:0] vout_ov_warn,
  output logic [1:0] vout_uv_warn,
  output logic alert_n
);
  // ********************************************************
  // decoding helpers
  // ********************************************************
  // scale a linear word to a common fixed point for comparison
  function automatic logic signed [47:0] pcb_l11(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] sh;
    m = 48'(signed'(w[10:0]));
    sh = w[15:11] ^ 5'h10;
    return m <<< sh;
  endfunction : pcb_l11

  function automatic logic pcb_freq_ok(input logic [15:0] w);
    unique case (w)
      16'h0000, 16'hf3e8, 16'hfabc, 16'hfb52, 16'hfbe8,
      16'h023f, 16'h028a, 16'h02ee, 16'h03e8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : pcb_freq_ok

  // ********************************************************
  // registers
  // ********************************************************
  logic page;
  logic [15:0] nominal [2];
  logic [15:0] ceiling [2];
  logic [15:0] m_high [2];
  logic [15:0] m_low [2];
  logic [15:0] ov_fault_lvl [2];
  logic [15:0] ov_warn_lvl [2];
  logic [15:0] uv_warn_lvl [2];
  logic [15:0] uv_fault_lvl [2];
  logic [15:0] start_th;
  logic [15:0] stop_th;
  logic [15:0] in_ov_lvl;
  logic [15:0] in_uv_lvl;
  logic [7:0] alert_mask;
  logic [31:0] adc_cnt;
  logic adc_tick;
  logic [15:0] pll_cnt;

  logic take;
  logic wr_ok;
  logic wr_busy;
  logic rd_err;
  logic wr_err;
  logic [15:0] rd_data;
  logic any_active;
  logic clr;
  logic [15:0] status_word;

  assign take = ce & bus.req_valid;
  assign any_active = |(run & op_on);
  assign clr = take & bus.req_write & (bus.req_code == pcb_pkg::CMD_CLEAR_FAULTS);
  assign wr_ok = take & bus.req_write & ~wr_err;

  always_comb begin
    wr_err = 1'b0;
    wr_busy = 1'b0;
    unique case (bus.req_code)
      pcb_pkg::CMD_PAGE: wr_err = |bus.req_data[7:1];
      pcb_pkg::CMD_FREQ, pcb_pkg::CMD_PHASE: begin
        wr_busy = any_active;
        wr_err = any_active | ((bus.req_code == pcb_pkg::CMD_FREQ) &
                 ~pcb_freq_ok(bus.req_data));
      end
      pcb_pkg::CMD_OUT_OV_FAULT:
        wr_err = bus.req_data > pcb_pkg::RST_HARD_MAX;
      pcb_pkg::CMD_CLEAR_FAULTS, pcb_pkg::CMD_NOMINAL,
      pcb_pkg::CMD_CEILING, pcb_pkg::CMD_MARGIN_HIGH,
      pcb_pkg::CMD_MARGIN_LOW, pcb_pkg::CMD_START_TH,
      pcb_pkg::CMD_STOP_TH, pcb_pkg::CMD_OUT_OV_WARN,
      pcb_pkg::CMD_OUT_UV_WARN, pcb_pkg::CMD_OUT_UV_FAULT,
      pcb_pkg::CMD_IN_OV_FAULT, pcb_pkg::CMD_IN_UV_WARN,
      pcb_pkg::CMD_ALERT_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1; // read-only or unknown codes
    endcase
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[pcb_pkg::SW_VOUT_BIT] = vout_ov_fault[page] |
      vout_uv_fault[page] | vout_ov_warn[page] | vout_uv_warn[page];
    status_word[pcb_pkg::SW_INPUT_BIT] = vin_ov_fault | vin_uv_warn;
    status_word[pcb_pkg::SW_BUSY_BIT] = busy_fault;
    status_word[pcb_pkg::SW_NONE_ABOVE_BIT] =
      vout_ov_warn[page] | vout_uv_warn[page];
  end

  always_comb begin
    rd_err = 1'b0;
    rd_data = 16'h0000;
    unique case (bus.req_code)
      pcb_pkg::CMD_PAGE: rd_data = {15'h0000, page};
      pcb_pkg::CMD_FORMAT: rd_data = {8'h00, pcb_pkg::RST_FORMAT};
      pcb_pkg::CMD_NOMINAL: rd_data = nominal[page];
      pcb_pkg::CMD_CEILING: rd_data = ceiling[page];
      pcb_pkg::CMD_MARGIN_HIGH: rd_data = m_high[page];
      pcb_pkg::CMD_MARGIN_LOW: rd_data = m_low[page];
      pcb_pkg::CMD_OUT_OV_FAULT: rd_data = ov_fault_lvl[page];
      pcb_pkg::CMD_OUT_OV_WARN: rd_data = ov_warn_lvl[page];
      pcb_pkg::CMD_OUT_UV_WARN: rd_data = uv_warn_lvl[page];
      pcb_pkg::CMD_OUT_UV_FAULT: rd_data = uv_fault_lvl[page];
      pcb_pkg::CMD_HARD_MAX: rd_data = pcb_pkg::RST_HARD_MAX;
      pcb_pkg::CMD_START_TH: rd_data = start_th;
      pcb_pkg::CMD_STOP_TH: rd_data = stop_th;
      pcb_pkg::CMD_IN_OV_FAULT: rd_data = in_ov_lvl;
      pcb_pkg::CMD_IN_UV_WARN: rd_data = in_uv_lvl;
      pcb_pkg::CMD_FREQ: rd_data = freq_select;
      pcb_pkg::CMD_PHASE: rd_data = {8'h00, phase_config};
      pcb_pkg::CMD_ALERT_MASK: rd_data = {8'h00, alert_mask};
      pcb_pkg::CMD_STATUS_WORD: rd_data = status_word;
      pcb_pkg::CMD_STATUS_OUT: begin
        rd_data[pcb_pkg::ST_OUT_OV_FAULT_BIT] = vout_ov_fault[page];
        rd_data[pcb_pkg::ST_OUT_OV_WARN_BIT] = vout_ov_warn[page];
        rd_data[pcb_pkg::ST_OUT_UV_WARN_BIT] = vout_uv_warn[page];
        rd_data[pcb_pkg::ST_OUT_UV_FAULT_BIT] = vout_uv_fault[page];
      end
      default: rd_err = 1'b1;
    endcase
  end

  // ********************************************************
  // response
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus.rsp_valid <= 1'b0;
      bus.rsp_err <= 1'b0;
      bus.rsp_data <= 16'h0000;
    end else if (ce) begin
      bus.rsp_valid <= bus.req_valid;
      bus.rsp_err <= bus.req_write ? wr_err : rd_err;
      bus.rsp_data <= bus.req_write ? 16'h0000 : rd_data;
    end
  end

  // ********************************************************
  // configuration writes
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      page <= 1'b0;
      for (int c = 0; c < pcb_pkg::CHANNELS; c++) begin
        nominal[c] <= pcb_pkg::RST_NOMINAL;
        ceiling[c] <= pcb_pkg::RST_CEILING;
        m_high[c] <= pcb_pkg::RST_MARGIN_HIGH;
        m_low[c] <= pcb_pkg::RST_MARGIN_LOW;
        ov_fault_lvl[c] <= pcb_pkg::RST_OUT_OV_FAULT;
        ov_warn_lvl[c] <= pcb_pkg::RST_OUT_OV_WARN;
        uv_warn_lvl[c] <= pcb_pkg::RST_OUT_UV_WARN;
        uv_fault_lvl[c] <= pcb_pkg::RST_OUT_UV_FAULT;
      end
      start_th <= pcb_pkg::RST_START_TH;
      stop_th <= pcb_pkg::RST_STOP_TH;
      in_ov_lvl <= pcb_pkg::RST_IN_OV_FAULT;
      in_uv_lvl <= pcb_pkg::RST_IN_UV_WARN;
      freq_select <= pcb_pkg::RST_FREQ;
      phase_config <= pcb_pkg::RST_PHASE;
      alert_mask <= pcb_pkg::RST_ALERT_MASK;
    end else if (ce && wr_ok) begin
      unique case (bus.req_code)
        pcb_pkg::CMD_PAGE: page <= bus.req_data[0];
        pcb_pkg::CMD_NOMINAL: nominal[page] <= bus.req_data;
        pcb_pkg::CMD_CEILING: ceiling[page] <= bus.req_data;
        pcb_pkg::CMD_MARGIN_HIGH: m_high[page] <= bus.req_data;
        pcb_pkg::CMD_MARGIN_LOW: m_low[page] <= bus.req_data;
        pcb_pkg::CMD_OUT_OV_FAULT: ov_fault_lvl[page] <= bus.req_data;
        pcb_pkg::CMD_OUT_OV_WARN: ov_warn_lvl[page] <= bus.req_data;
        pcb_pkg::CMD_OUT_UV_WARN: uv_warn_lvl[page] <= bus.req_data;
        pcb_pkg::CMD_OUT_UV_FAULT: uv_fault_lvl[page] <= bus.req_data;
        pcb_pkg::CMD_START_TH: start_th <= bus.req_data;
        pcb_pkg::CMD_STOP_TH: stop_th <= bus.req_data;
        pcb_pkg::CMD_IN_OV_FAULT: in_ov_lvl <= bus.req_data;
        pcb_pkg::CMD_IN_UV_WARN: in_uv_lvl <= bus.req_data;
        pcb_pkg::CMD_FREQ: freq_select <= bus.req_data;
        pcb_pkg::CMD_PHASE:
          phase_config <= bus.req_data[7:0] & pcb_pkg::PHASE_WRITABLE;
        pcb_pkg::CMD_ALERT_MASK: alert_mask <= bus.req_data[7:0];
        default: page <= page;
      endcase
    end
  end

  // ********************************************************
  // busy fault and pll lock
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_fault <= 1'b0;
    end else if (ce) begin
      // set wins over a clear in the same cycle
      if (take && bus.req_write && wr_busy) begin
        busy_fault <= 1'b1;
      end else if (clr) begin
        busy_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pll_cnt <= 16'h0000;
      pll_unlock <= 1'b0;
      ext_osc <= 1'b1;
    end else if (ce) begin
      ext_osc <= freq_select == pcb_pkg::FREQ_EXT_OSC;
      if (wr_ok && bus.req_code == pcb_pkg::CMD_FREQ &&
          bus.req_data != freq_select) begin
        pll_cnt <= 16'(pcb_pkg::PLL_SETTLE_CYCLES);
        pll_unlock <= 1'b1;
      end else if (pll_cnt != 16'h0000) begin
        pll_cnt <= pll_cnt - 16'h0001;
        pll_unlock <= pll_cnt != 16'h0001;
      end
    end
  end

  // ********************************************************
  // adc-paced monitors
  // ********************************************************
  // limits are judged once per adc period, so detection lags by up to it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adc_cnt <= 32'h00000000;
      adc_tick <= 1'b0;
    end else if (ce) begin
      adc_tick <= adc_cnt == 32'(ADC_CYCLES - 1);
      adc_cnt <= (adc_cnt == 32'(ADC_CYCLES - 1)) ? 32'h00000000 :
                 adc_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vin_ov_fault <= 1'b0;
      vin_uv_warn <= 1'b0;
      conv_enable <= 2'b00;
    end else if (ce) begin
      if (adc_tick && pcb_l11(vin_level) > pcb_l11(in_ov_lvl)) begin
        vin_ov_fault <= 1'b1;
      end else if (clr) begin
        vin_ov_fault <= 1'b0;
      end
      if (adc_tick && pcb_l11(vin_level) < pcb_l11(in_uv_lvl)) begin
        vin_uv_warn <= 1'b1;
      end else if (clr) begin
        vin_uv_warn <= 1'b0;
      end
      if (adc_tick && pcb_l11(vin_level) >= pcb_l11(start_th)) begin
        conv_enable <= run & op_on;
      end else if (adc_tick && pcb_l11(vin_level) <= pcb_l11(stop_th)) begin
        conv_enable <= 2'b00;
      end else begin
        conv_enable <= conv_enable & run & op_on;
      end
    end
  end

  generate
    for (genvar c = 0; c < pcb_pkg::CHANNELS; c++) begin : g_ch
      logic [15:0] sel;
      logic [15:0] cap;
      always_comb begin
        unique case (margin_sel[c])
          2'b01: sel = m_high[c];
          2'b10: sel = m_low[c];
          default: sel = nominal[c];
        endcase
        cap = (ceiling[c] < pcb_pkg::RST_HARD_MAX) ? ceiling[c] :
              pcb_pkg::RST_HARD_MAX;
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          vout_target[c] <= pcb_pkg::RST_NOMINAL;
          vout_ov_fault[c] <= 1'b0;
          vout_uv_fault[c] <= 1'b0;
          vout_ov_warn[c] <= 1'b0;
          vout_uv_warn[c] <= 1'b0;
        end else if (ce) begin
          vout_target[c] <= (sel > cap) ? cap : sel;
          if (adc_tick && vout_sense[c] > ov_fault_lvl[c]) begin
            vout_ov_fault[c] <= 1'b1;
          end else if (clr) begin
            vout_ov_fault[c] <= 1'b0;
          end
          if (adc_tick && vout_sense[c] < uv_fault_lvl[c]) begin
            vout_uv_fault[c] <= 1'b1;
          end else if (clr) begin
            vout_uv_fault[c] <= 1'b0;
          end
          if (adc_tick && vout_sense[c] > ov_warn_lvl[c]) begin
            vout_ov_warn[c] <= 1'b1;
          end else if (clr) begin
            vout_ov_warn[c] <= 1'b0;
          end
          if (adc_tick && vout_sense[c] < uv_warn_lvl[c]) begin
            vout_uv_warn[c] <= 1'b1;
          end else if (clr) begin
            vout_uv_warn[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      alert_n <= 1'b1;
    end else if (ce) begin
      alert_n <= ~((|vout_ov_warn & ~alert_mask[pcb_pkg::MASK_OV_WARN_BIT]) |
                   (|vout_uv_warn & ~alert_mask[pcb_pkg::MASK_UV_WARN_BIT]) |
                   (|vout_ov_fault) | (|vout_uv_fault) |
                   vin_ov_fault | busy_fault);
    end
  end
endmodule : pcb_device

/* rtl/pcb_host.sv */
// host end: issues one command at a time, screens unsafe values
// assumes the device answers every request with rsp_valid
`timescale 1ns/1ns
module pcb_host (
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  pcb_if.host bus,
  input wire logic cmd_go,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic multiphase_ok,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_err,
  output logic cmd_refused,
  output logic [15:0] cmd_rdata
);
  typedef enum logic [0:0] {PCB_IDLE, PCB_WAIT} pcb_state_t;
  pcb_state_t state;
  logic page;
  logic [15:0] nominal [2];
  logic bad;
  logic [7:0] code_q;
  logic [15:0] data_q;
  logic wr_q;

  // ********************************************************
  // screening
  // ********************************************************
  // shadow of nominal only tracks writes made through this host
  always_comb begin
    bad = 1'b0;
    if (cmd_write) begin
      unique case (cmd_code)
        pcb_pkg::CMD_PHASE:
          bad = cmd_data[pcb_pkg::PHASE_SHARED_EA_BIT] & ~multiphase_ok;
        pcb_pkg::CMD_MARGIN_HIGH:
          bad = cmd_data <= nominal[page];
        pcb_pkg::CMD_MARGIN_LOW:
          bad = cmd_data >= nominal[page];
        default: bad = 1'b0;
      endcase
    end
  end

  // ********************************************************
  // request sequencing
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= PCB_IDLE;
      bus.req_valid <= 1'b0;
      bus.req_write <= 1'b0;
      bus.req_code <= 8'h00;
      bus.req_data <= 16'h0000;
      cmd_busy <= 1'b0;
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else if (ce) begin
      bus.req_valid <= 1'b0;
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
      unique case (state)
        PCB_IDLE: begin
          if (cmd_go && bad) begin
            cmd_refused <= 1'b1;
          end else if (cmd_go) begin
            bus.req_valid <= 1'b1;
            bus.req_write <= cmd_write;
            bus.req_code <= cmd_code;
            bus.req_data <= cmd_data;
            cmd_busy <= 1'b1;
            state <= PCB_WAIT;
          end
        end
        PCB_WAIT: begin
          if (bus.rsp_valid) begin
            cmd_done <= 1'b1;
            cmd_busy <= 1'b0;
            cmd_err <= bus.rsp_err;
            cmd_rdata <= bus.rsp_data;
            state <= PCB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      page <= 1'b0;
      nominal[0] <= pcb_pkg::RST_NOMINAL;
      nominal[1] <= pcb_pkg::RST_NOMINAL;
      code_q <= 8'h00;
      data_q <= 16'h0000;
      wr_q <= 1'b0;
    end else if (ce) begin
      if (bus.req_valid) begin
        code_q <= bus.req_code;
        data_q <= bus.req_data;
        wr_q <= bus.req_write;
      end
      if (bus.rsp_valid && !bus.rsp_err && wr_q) begin
        if (code_q == pcb_pkg::CMD_PAGE) begin
          page <= data_q[0];
        end
        if (code_q == pcb_pkg::CMD_NOMINAL) begin
          nominal[page] <= data_q;
        end
      end
    end
  end
endmodule : pcb_host

/* rtl/pcb_if.sv */
// command link between the host end and the device end
// assumes both ends share clk; one request outstanding at a time
`timescale 1ns/1ns
interface pcb_if;
  logic req_valid;
  logic req_write;
  logic [7:0] req_code;
  logic [15:0] req_data;
  logic rsp_valid;
  logic rsp_err;
  logic [15:0] rsp_data;
  modport dev (
    input req_valid,
    input req_write,
    input req_code,
    input req_data,
    output rsp_valid,
    output rsp_err,
    output rsp_data
  );
  modport host (
    output req_valid,
    output req_write,
    output req_code,
    output req_data,
    input rsp_valid,
    input rsp_err,
    input rsp_data
  );
endinterface : pcb_if

/* rtl/pcb_pkg.sv */
// constants shared by both ends of the power configuration command bank
// assumes one 250 MHz clock common to both ends
package pcb_pkg;
  // ********************************************************
  // command codes
  // ********************************************************
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_FORMAT = 8'h20;
  localparam logic [7:0] CMD_NOMINAL = 8'h21;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_START_TH = 8'h35;
  localparam logic [7:0] CMD_STOP_TH = 8'h36;
  localparam logic [7:0] CMD_OUT_OV_FAULT = 8'h40;
  localparam logic [7:0] CMD_OUT_OV_WARN = 8'h42;
  localparam logic [7:0] CMD_OUT_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_OUT_UV_FAULT = 8'h44;
  localparam logic [7:0] CMD_IN_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_IN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_OUT = 8'h7a;
  localparam logic [7:0] CMD_HARD_MAX = 8'ha5;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hf0;
  localparam logic [7:0] CMD_PHASE = 8'hf5;
  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] RST_FORMAT = 8'h14;
  localparam logic [15:0] RST_NOMINAL = 16'h1000;
  localparam logic [15:0] RST_CEILING = 16'h599a;
  localparam logic [15:0] RST_MARGIN_HIGH = 16'h10cd;
  localparam logic [15:0] RST_MARGIN_LOW = 16'h0f33;
  localparam logic [15:0] RST_START_TH = 16'hcac0;
  localparam logic [15:0] RST_STOP_TH = 16'hcaa0;
  localparam logic [15:0] RST_OUT_OV_FAULT = 16'h119a;
  localparam logic [15:0] RST_OUT_OV_WARN = 16'h1133;
  localparam logic [15:0] RST_OUT_UV_WARN = 16'h0ecd;
  localparam logic [15:0] RST_OUT_UV_FAULT = 16'h0e66;
  localparam logic [15:0] RST_IN_OV_FAULT = 16'hda2e;
  localparam logic [15:0] RST_IN_UV_WARN = 16'hcaa6;
  localparam logic [15:0] RST_HARD_MAX = 16'h5b34;
  localparam logic [15:0] RST_FREQ = 16'h0000;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_ALERT_MASK = 8'h00;
  // ********************************************************
  // fields
  // ********************************************************
  localparam int PHASE_SHARED_EA_BIT = 7;
  localparam int PHASE_SHARE_CLK_BIT = 4;
  localparam logic [7:0] PHASE_WRITABLE = 8'h97;
  localparam logic [15:0] FREQ_EXT_OSC = 16'h0000;
  localparam int ST_OUT_OV_FAULT_BIT = 7;
  localparam int ST_OUT_OV_WARN_BIT = 6;
  localparam int ST_OUT_UV_WARN_BIT = 5;
  localparam int ST_OUT_UV_FAULT_BIT = 4;
  localparam int SW_VOUT_BIT = 15;
  localparam int SW_INPUT_BIT = 13;
  localparam int SW_BUSY_BIT = 7;
  localparam int SW_NONE_ABOVE_BIT = 0;
  localparam int MASK_OV_WARN_BIT = 1;
  localparam int MASK_UV_WARN_BIT = 0;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADC_LAG_MS = 90;
  localparam int ADC_LAG_CYCLES = ADC_LAG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PLL_SETTLE_NS = 1000;
  localparam int PLL_SETTLE_CYCLES =
    (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHANNELS = 2;
endpackage : pcb_pkg

/* tb/pcb_link_assertions.sv */
// checks on the command link between the host end and the device end
// assumes ce is held high, so every clock is a live cycle
`timescale 1ns/1ns
module pcb_link_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_data,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_data
);
  // ********************************************************
  // link properties
  // ********************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd, wr, freq_ok;
  assign rd = req_valid && !req_write;
  assign wr = req_valid && req_write;
  assign freq_ok = req_data inside {16'h0000, 16'hf3e8, 16'hfabc, 16'hfb52,
    16'hfbe8, 16'h023f, 16'h028a, 16'h02ee, 16'h03e8};
  chk_answer_follows: assert property (req_valid |=> rsp_valid)
    else $error("request left without answer");
  chk_no_stray: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  chk_write_zero: assert property (wr |=> rsp_data == 16'h0000)
    else $error("write answer carries data");
  chk_format_fixed: assert property (rd && req_code == 8'h20 |=>
    !rsp_err && rsp_data == 16'h0014) else $error("format byte wrong");
  chk_format_ro: assert property (wr && req_code == 8'h20 |=> rsp_err)
    else $error("format byte write taken");
  chk_hard_max: assert property (rd && req_code == 8'ha5 |=>
    rsp_data == 16'h5b34) else $error("hard max word wrong");
  chk_hard_ro: assert property (wr && req_code == 8'ha5 |=> rsp_err)
    else $error("hard max write taken");
  chk_freq_list: assert property (wr && req_code == 8'h33 && !freq_ok
    |=> rsp_err) else $error("unlisted frequency taken");
  chk_ov_over_max: assert property (wr && req_code == 8'h40 &&
    req_data > 16'h5b34 |=> rsp_err) else $error("fault level over max");
  chk_input_shared: assert property (wr && req_code inside {8'h35,
    8'h36, 8'h55, 8'h58} |=> !rsp_err) else $error("input limit refused");
endmodule : pcb_link_assertions

/* tb/tb.sv */
// bench joining host and device ends through the command link
// assumes the monitor tick is shortened to 8 cycles
`timescale 1ns/1ns
module tb;
  logic clk, nrst, go, w, mp, done, err, rf, rfq, hb, alert_n;
  logic ext, unl, bsy, vov, vuw;
  logic [7:0] code, ph;
  logic [15:0] data, rdata, vin, freq, rnd;
  logic [1:0] run, opon, conv, ovf, uvf, uvw, ovw;
  logic [1:0][1:0] msel;
  logic [1:0][15:0] vs, tgt;
  int miscompares, n_tests, cyc, seed, i;
  localparam logic [7:0] RC [14] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26,
    8'h35, 8'h36, 8'h40, 8'h42, 8'h43, 8'h44, 8'h55, 8'h58, 8'ha5};
  localparam logic [15:0] RV [14] = '{16'h0014, 16'h1000, 16'h599a,
    16'h10cd, 16'h0f33, 16'hcac0, 16'hcaa0, 16'h119a, 16'h1133, 16'h0ecd,
    16'h0e66, 16'hda2e, 16'hcaa6, 16'h5b34};
  localparam logic [15:0] FQ [9] = '{16'hf3e8, 16'hfabc, 16'hfb52,
    16'hfbe8, 16'h023f, 16'h028a, 16'h02ee, 16'h03e8, 16'h0000};
  pcb_if i_pcb_if ();
  pcb_device #(.ADC_CYCLES(8)) i_pcb_device (.clk, .ce(1'b1), .nrst,
    .bus(i_pcb_if), .run, .op_on(opon), .margin_sel(msel), .vin_level(vin),
    .vout_sense(vs), .conv_enable(conv), .vout_target(tgt),
    .phase_config(ph), .freq_select(freq), .ext_osc(ext), .pll_unlock(unl),
    .busy_fault(bsy), .vin_ov_fault(vov), .vin_uv_warn(vuw),
    .vout_ov_fault(ovf), .vout_uv_fault(uvf), .vout_ov_warn(ovw),
    .vout_uv_warn(uvw), .alert_n);
  pcb_host i_pcb_host (.clk, .ce(1'b1), .nrst, .bus(i_pcb_if), .cmd_go(go),
    .cmd_write(w), .cmd_code(code), .cmd_data(data), .multiphase_ok(mp),
    .cmd_busy(hb), .cmd_done(done), .cmd_err(err), .cmd_refused(rf),
    .cmd_rdata(rdata));
  pcb_link_assertions i_chk (.clk, .nrst,
    .req_valid(i_pcb_if.req_valid), .req_write(i_pcb_if.req_write),
    .req_code(i_pcb_if.req_code), .req_data(i_pcb_if.req_data),
    .rsp_valid(i_pcb_if.rsp_valid), .rsp_err(i_pcb_if.rsp_err),
    .rsp_data(i_pcb_if.rsp_data));
  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [15:0] cap(logic [15:0] v, logic [15:0] c);
    return (v > c) ? c : v;
  endfunction : cap
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // refused pulse comes early, done later; either ends the wait
  task cmd(input logic wr, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    go <= 1'b1;
    w <= wr;
    code <= c;
    data <= d;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      #1;
      if (done === 1'b1 || rf === 1'b1) break;
      @(posedge clk);
    end
    chk({done | rf, hb}, 16'h0002);
    rfq = rf;
  endtask : cmd
  task end_of_test;
    $display("mismatches %0d of %0d checks", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ********************************************************
  // clock, watchdog, sequence
  // ********************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    {nrst, go, w, mp, code, data, run, opon, msel} = '0;
    vin = 16'hcb00;
    vs = {16'h1000, 16'h1000};
    seed = 5809;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 14; i++) begin
      cmd(1'b0, RC[i], 16'h0000);
      chk(rdata, RV[i]);
    end
    cmd(1'b1, 8'h20, 16'h0015);
    chk(err, 16'h1);
    cmd(1'b1, 8'ha5, 16'h0000);
    chk(err, 16'h1);
    cmd(1'b1, 8'h40, 16'h6000);
    chk(err, 16'h1);
    @(posedge clk);
    run <= 2'b11;
    opon <= 2'b01;
    cmd(1'b1, 8'h33, 16'hf3e8);
    chk(err, 16'h1);
    chk(bsy, 16'h1);
    chk(freq, 16'h0000);
    cmd(1'b1, 8'hf5, 16'h0001);
    chk(err, 16'h1);
    chk(ph, 16'h0000);
    @(posedge clk);
    run <= 2'b00;
    for (i = 0; i < 9; i++) begin
      cmd(1'b1, 8'h33, FQ[i]);
      chk(err, 16'h0);
      chk(freq, FQ[i]);
      chk(ext, FQ[i] == 16'h0000);
      if (i == 0) chk(unl, 16'h1);
    end
    cmd(1'b1, 8'h33, 16'h1234);
    chk(err, 16'h1);
    cmd(1'b1, 8'hf5, 16'h006d);
    chk(ph, 16'h0005);
    cmd(1'b1, 8'hf5, 16'h0081);
    chk(rfq, 16'h1);
    cmd(1'b1, 8'h25, 16'h0f00);
    chk(rfq, 16'h1);
    cmd(1'b1, 8'h26, 16'h1100);
    chk(rfq, 16'h1);
    cmd(1'b1, 8'h24, 16'h1050);
    @(posedge clk);
    msel <= {2'b00, 2'b01};
    repeat (3) @(posedge clk);
    #1 chk(tgt[0], cap(16'h10cd, 16'h1050));
    for (i = 0; i < 3; i++) begin
      rnd = 16'($random(seed));
      cmd(1'b1, RC[8 + i], rnd);
      cmd(1'b0, RC[8 + i], 16'h0000);
      chk(rdata, rnd);
    end
    cmd(1'b1, 8'h00, 16'h0001);
    cmd(1'b1, 8'h21, 16'h1111);
    cmd(1'b1, 8'h55, 16'hda40);
    cmd(1'b1, 8'h00, 16'h0000);
    cmd(1'b0, 8'h21, 16'h0000);
    chk(rdata, 16'h1000);
    cmd(1'b0, 8'h55, 16'h0000);
    chk(rdata, 16'hda40);
    @(posedge clk);
    vin <= 16'hdb00;
    run <= 2'b11;
    opon <= 2'b11;
    vs <= {16'h0100, 16'h2000};
    repeat (12) @(posedge clk);
    #1 chk(vov, 16'h1);
    chk(conv, 16'h3);
    chk(ovf[0], 16'h1);
    chk(uvf[1], 16'h1);
    chk(uvw[1], 16'h1);
    chk(ovw[1], 16'h0);
    chk(alert_n, 16'h0);
    @(posedge clk);
    vin <= 16'hca00;
    repeat (12) @(posedge clk);
    #1 chk(conv, 16'h0);
    chk(vuw, 16'h1);
    end_of_test;
  end
endmodule : tb
